// ===== core/dfp_pkg.sv
// Purpose: Shared codes, types and CRC helpers for the data frame packer ends
// Assumes: One symbol = 8 bits plus a K flag; a link word holds four symbols
// Notes:   Lane 0 (bits 7:0) is the first symbol on the wire
package dfp_pkg;

  // ==========================================================
  // Symbol codes
  localparam logic [7:0] K_COMMA  = 8'hfc;  // K28.7
  localparam logic [7:0] K_EDF    = 8'h1c;  // K28.0, not a comma
  localparam logic [7:0] K_EOP    = 8'hfd;  // K29.7
  localparam logic [7:0] K_EEP    = 8'hfe;  // K30.7
  localparam logic [7:0] K_FILL   = 8'hfb;  // K27.7
  localparam logic [7:0] D_SDF_ID = 8'h50;  // Data symbol naming an SDF
  localparam logic [7:0] D_RSVD   = 8'h00;  // D0.0
  localparam logic [3:0] KF_CTRL  = 4'h1;   // Control word: K flag on lane 0 only

  // ==========================================================
  // Frame limits and CRC
  localparam int          MAX_WORDS = 64;
  localparam int          LANES     = 4;
  localparam logic [15:0] CRC_POLY  = 16'h1021;
  localparam logic [15:0] CRC_INIT  = 16'hffff;

  typedef enum logic [1:0] {
    NC_DATA = 2'b00,
    NC_EOP  = 2'b01,
    NC_EEP  = 2'b10,
    NC_FILL = 2'b11
  } dfp_nchar_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_DATA = 1'b1
  } dfp_state_type;

  // ==========================================================
  // Helpers
  function automatic logic [8:0] dfp_encode(dfp_nchar_type kind, logic [7:0] data);
    logic [8:0] r;
    r = {1'b0, data};
    unique case (kind)
      NC_DATA: r = {1'b0, data};
      NC_EOP:  r = {1'b1, K_EOP};
      NC_EEP:  r = {1'b1, K_EEP};
      NC_FILL: r = {1'b1, K_FILL};
    endcase
    return r;
  endfunction

  function automatic dfp_nchar_type dfp_decode(logic k, logic [7:0] b);
    dfp_nchar_type r;
    r = NC_DATA;
    if (k && b == K_EOP)
      r = NC_EOP;
    else if (k && b == K_EEP)
      r = NC_EEP;
    else if (k)
      r = NC_FILL;
    return r;
  endfunction

  // MSB-first CRC over the n lowest byte lanes, lane 0 first
  function automatic logic [15:0] dfp_crc_word(logic [15:0] c, logic [31:0] w, int n);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < n; i++)
    begin
      r = r ^ {w[i*8 +: 8], 8'h00};
      for (int j = 0; j < 8; j++)
      begin
        r = r[15] ? ((r << 1) ^ CRC_POLY) : (r << 1);
      end
    end
    return r;
  endfunction

endpackage

// ===== core/dfp_link_if.sv
// Purpose: Word link between the frame packer and the frame receiver
// Assumes: Both ends share one clock; valid/ready handshake per word
// Notes:   kflag bit i marks lane i of word as a control symbol
interface dfp_link_if;
  logic [31:0] word;
  logic [3:0]  kflag;
  logic        valid;
  logic        ready;

  modport tx (output word, output kflag, output valid, input ready);
  modport rx (input word, input kflag, input valid, output ready);
endinterface

// ===== core/dfp_tx.sv
// Purpose: Packs N-Chars into words and wraps them in SDF/EDF data frames
// Assumes: Sequence number and VC come from the quality layer as levels
// Notes:   Only the data frame type is built here
//
// How it works
// - Data byte sent as equal data symbol
// - EOP sent as K29.7
// - EEP sent as K30.7
// - Packet end accepted at any lane
// - Char after packet end starts next packet
// - Fill sent as K27.7
// - Fills only after EOP or EEP
// - Zero to three Fills per run
// - Pad short tail word with Fills
// - Tail ending in packet end sent at once
// - Fills carried and buffered at receiver
// - Data frame type only
// - Data frame opens with SDF
// - Data frame closes with EDF
// - One to 64 words per frame
// - Four characters per data word
// - SDF names VC; receiver routes by it
// - SDF reserved is D0.0, ignored on receipt
// - EDF CRC covers SDF, data, EDF
// - EDF carries frame sequence number
// - EDF order: K28.0, seq, CRC lo, hi
module dfp_tx #(
  parameter int MAX_WORDS = dfp_pkg::MAX_WORDS
) (
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic                  nc_valid,
  input  wire logic [7:0]            nc_data,
  input  wire dfp_pkg::dfp_nchar_type nc_kind,
  output logic                       nc_ready,
  input  wire logic [7:0]            vc_num,
  input  wire logic [7:0]            seq_num,
  output logic                       frame_open,
  dfp_link_if.tx                     lk
);

  // ==========================================================
  // Elaboration checks
  generate
    if (MAX_WORDS < 1 || MAX_WORDS > dfp_pkg::MAX_WORDS)
    begin : g_bad_len
      $error("dfp_tx: MAX_WORDS must lie in 1..64");
    end
  endgenerate

  // ==========================================================
  // Character packer
  logic [31:0]            acc_r;
  logic [31:0]            acc_nxt;
  logic [3:0]             acck_r;
  logic [3:0]             acck_nxt;
  logic [2:0]             lane_r;
  logic [2:0]             lane_nxt;
  logic                   done_r;
  logic                   done_nxt;
  logic                   ready_r;
  logic                   take;
  logic                   is_end;
  logic                   closes;
  logic [8:0]             sym;
  logic                   word_sent;

  assign take   = nc_valid && ready_r;
  assign is_end = (nc_kind == dfp_pkg::NC_EOP) || (nc_kind == dfp_pkg::NC_EEP);
  // Packet end closes the word at once so its tail is not held back
  assign closes = take && (is_end || lane_r == 3'(dfp_pkg::LANES - 1));
  assign sym    = dfp_pkg::dfp_encode(nc_kind, nc_data);

  genvar l;
  generate
    for (l = 0; l < dfp_pkg::LANES; l++)
    begin : g_lane
      wire put_here = take && (lane_r == 3'(l));
      wire put_fill = take && is_end && (lane_r < 3'(l));
      assign acc_nxt[l*8 +: 8] = put_here ? sym[7:0]
                               : put_fill ? dfp_pkg::K_FILL
                               : acc_r[l*8 +: 8];
      assign acck_nxt[l]       = put_here ? sym[8]
                               : put_fill ? 1'b1
                               : acck_r[l];
    end
  endgenerate

  // Next char after a packet end lands in lane 0 of a fresh word
  assign lane_nxt = closes ? 3'd0 : take ? lane_r + 3'd1 : lane_r;
  assign done_nxt = closes ? 1'b1 : word_sent ? 1'b0 : done_r;
  assign nc_ready = ready_r;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      acc_r   <= 32'h0;
      acck_r  <= 4'h0;
      lane_r  <= 3'h0;
      done_r  <= 1'b0;
      ready_r <= 1'b0;
    end
    else
    begin
      acc_r   <= acc_nxt;
      acck_r  <= acck_nxt;
      lane_r  <= lane_nxt;
      done_r  <= done_nxt;
      ready_r <= !done_nxt;
    end
  end

  // ==========================================================
  // Frame sequencer
  dfp_pkg::dfp_state_type st_r;
  dfp_pkg::dfp_state_type st_nxt;
  logic [6:0]             cnt_r;
  logic [6:0]             cnt_nxt;
  logic [15:0]            crc_r;
  logic [15:0]            crc_nxt;
  logic [31:0]            word_r;
  logic [31:0]            word_nxt;
  logic [3:0]             kf_r;
  logic [3:0]             kf_nxt;
  logic                   valid_r;
  logic                   valid_nxt;
  logic                   open_r;
  logic                   load;
  logic                   emit;
  logic                   room;
  logic [31:0]            sdf_word;
  logic [31:0]            edf_head;
  logic [15:0]            edf_crc;
  logic [31:0]            edf_word;

  // Output stage may be refilled when empty or being drained
  assign load     = !valid_r || lk.ready;
  assign room     = cnt_r != 7'(MAX_WORDS);
  assign sdf_word = {dfp_pkg::D_RSVD, vc_num, dfp_pkg::D_SDF_ID, dfp_pkg::K_COMMA};
  assign edf_head = {16'h0000, seq_num, dfp_pkg::K_EDF};
  assign edf_crc  = dfp_pkg::dfp_crc_word(crc_r, edf_head, 2);
  assign edf_word = {edf_crc[15:8], edf_crc[7:0], seq_num, dfp_pkg::K_EDF};

  // A frame stays open only while words keep coming, so a slow
  // source costs extra SDF/EDF overhead rather than link stalls.
  always_comb
  begin
    st_nxt    = st_r;
    cnt_nxt   = cnt_r;
    crc_nxt   = crc_r;
    word_nxt  = word_r;
    kf_nxt    = kf_r;
    emit      = 1'b0;
    word_sent = 1'b0;
    unique case (st_r)
      dfp_pkg::ST_IDLE:
      begin
        if (done_r && load)
        begin
          emit     = 1'b1;
          word_nxt = sdf_word;
          kf_nxt   = dfp_pkg::KF_CTRL;
          crc_nxt  = dfp_pkg::dfp_crc_word(dfp_pkg::CRC_INIT, sdf_word, 4);
          cnt_nxt  = 7'd0;
          st_nxt   = dfp_pkg::ST_DATA;
        end
      end
      dfp_pkg::ST_DATA:
      begin
        if (load && done_r && room)
        begin
          emit      = 1'b1;
          word_sent = 1'b1;
          word_nxt  = acc_r;
          kf_nxt    = acck_r;
          crc_nxt   = dfp_pkg::dfp_crc_word(crc_r, acc_r, 4);
          cnt_nxt   = cnt_r + 7'd1;
        end
        else if (load)
        begin
          // Entered with a word pending, so at least one was sent
          emit     = 1'b1;
          word_nxt = edf_word;
          kf_nxt   = dfp_pkg::KF_CTRL;
          st_nxt   = dfp_pkg::ST_IDLE;
        end
      end
    endcase
  end

  assign valid_nxt = emit ? 1'b1 : lk.ready ? 1'b0 : valid_r;

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r    <= dfp_pkg::ST_IDLE;
      cnt_r   <= 7'd0;
      crc_r   <= dfp_pkg::CRC_INIT;
      word_r  <= 32'h0;
      kf_r    <= 4'h0;
      valid_r <= 1'b0;
      open_r  <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      crc_r   <= crc_nxt;
      word_r  <= word_nxt;
      kf_r    <= kf_nxt;
      valid_r <= valid_nxt;
      open_r  <= st_nxt == dfp_pkg::ST_DATA;
    end
  end

  assign lk.word    = word_r;
  assign lk.kflag   = kf_r;
  assign lk.valid   = valid_r;
  assign frame_open = open_r;

endmodule

// ===== core/dfp_rx.sv
// Purpose: Receives data frames and unpacks words into N-Chars
// Assumes: Words arrive already aligned; no user back-pressure
// Notes:   Fills are passed on like any other N-Char
module dfp_rx (
  input  wire logic           clock,
  input  wire logic           nrst,
  dfp_link_if.rx              lk,
  output logic                nc_valid,
  output logic [7:0]          nc_data,
  output dfp_pkg::dfp_nchar_type nc_kind,
  output logic [7:0]          nc_vc,
  output logic                frame_end,
  output logic                crc_ok,
  output logic [7:0]          seq_num,
  output logic                code_err
);

  // ==========================================================
  // Word decode
  logic [31:0]            hold_r;
  logic [3:0]             holdk_r;
  logic [1:0]             lane_r;
  logic                   busy_r;
  logic                   ready_r;
  logic                   in_frame_r;
  logic [7:0]             vc_r;
  logic [15:0]            crc_r;
  logic                   take;
  logic                   is_sdf;
  logic                   is_edf;
  logic                   is_data;
  logic                   busy_nxt;
  logic [7:0]             cur_b;
  logic                   cur_k;
  logic [15:0]            edf_crc;

  assign take    = lk.valid && ready_r;
  // Reserved SDF symbol is not looked at
  assign is_sdf  = take && lk.kflag[0] && lk.word[7:0] == dfp_pkg::K_COMMA
                   && lk.word[15:8] == dfp_pkg::D_SDF_ID;
  assign is_edf  = take && in_frame_r && lk.kflag[0] && lk.word[7:0] == dfp_pkg::K_EDF;
  assign is_data = take && in_frame_r && !is_sdf && !is_edf;
  assign edf_crc = dfp_pkg::dfp_crc_word(crc_r, lk.word, 2);
  assign busy_nxt = is_data ? 1'b1 : (busy_r && lane_r == 2'd3) ? 1'b0 : busy_r;
  assign cur_b   = hold_r[lane_r*8 +: 8];
  assign cur_k   = holdk_r[lane_r];

  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      hold_r     <= 32'h0;
      holdk_r    <= 4'h0;
      lane_r     <= 2'd0;
      busy_r     <= 1'b0;
      ready_r    <= 1'b0;
      in_frame_r <= 1'b0;
      vc_r       <= 8'h0;
      crc_r      <= dfp_pkg::CRC_INIT;
    end
    else
    begin
      busy_r  <= busy_nxt;
      ready_r <= !busy_nxt;
      lane_r  <= busy_r ? lane_r + 2'd1 : 2'd0;
      if (is_sdf)
      begin
        in_frame_r <= 1'b1;
        vc_r       <= lk.word[23:16];
        crc_r      <= dfp_pkg::dfp_crc_word(dfp_pkg::CRC_INIT, lk.word, 4);
      end
      else if (is_edf)
        in_frame_r <= 1'b0;
      else if (is_data)
      begin
        hold_r  <= lk.word;
        holdk_r <= lk.kflag;
        crc_r   <= dfp_pkg::dfp_crc_word(crc_r, lk.word, 4);
      end
    end
  end

  // ==========================================================
  // N-Char and frame result outputs
  always_ff @(posedge clock or negedge nrst)
  begin
    if (!nrst)
    begin
      nc_valid  <= 1'b0;
      nc_data   <= 8'h0;
      nc_kind   <= dfp_pkg::NC_DATA;
      nc_vc     <= 8'h0;
      frame_end <= 1'b0;
      crc_ok    <= 1'b0;
      seq_num   <= 8'h0;
      code_err  <= 1'b0;
    end
    else
    begin
      nc_valid  <= busy_r;
      nc_data   <= cur_b;
      nc_kind   <= dfp_pkg::dfp_decode(cur_k, cur_b);
      nc_vc     <= vc_r;
      frame_end <= is_edf;
      if (is_edf)
      begin
        crc_ok  <= edf_crc == lk.word[31:16];
        seq_num <= lk.word[15:8];
      end
      code_err  <= busy_r && cur_k && cur_b != dfp_pkg::K_EOP
                   && cur_b != dfp_pkg::K_EEP && cur_b != dfp_pkg::K_FILL;
    end
  end

  assign lk.ready = ready_r;

endmodule

// ===== test/dfp_link_monitor.sv
// Purpose: Assertions on the word link between packer and receiver
// Assumes: One clock; nrst asynchronous, active low
// Notes:   Data words per frame are counted in helper logic
module dfp_link_monitor #(
  parameter int MAX_WORDS = dfp_pkg::MAX_WORDS
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic [31:0] word,
  input wire logic [3:0]  kflag,
  input wire logic        valid,
  input wire logic        ready
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Decode
  function automatic logic [3:0] lanes_are(logic [31:0] w, logic [3:0] k, logic [7:0] c);
    logic [3:0] r;
    for (int i = 0; i < 4; i++)
      r[i] = k[i] && w[i*8 +: 8] == c;
    return r;
  endfunction

  wire logic       take = valid && ready;
  wire logic       ctl  = kflag == dfp_pkg::KF_CTRL;
  wire logic       sdf  = ctl && word[7:0] == dfp_pkg::K_COMMA;
  wire logic       edf  = ctl && word[7:0] == dfp_pkg::K_EDF;
  wire logic [3:0] fl   = lanes_are(word, kflag, dfp_pkg::K_FILL);
  wire logic [3:0] en   = lanes_are(word, kflag, dfp_pkg::K_EOP) | lanes_are(word, kflag, dfp_pkg::K_EEP);
  logic [7:0]      cnt_r;

  // Only data words count; an SDF restarts the count
  always_ff @(posedge clock or negedge nrst)
    if (!nrst)
      cnt_r <= 8'h00;
    else if (take && sdf)
      cnt_r <= 8'h00;
    else if (take && !ctl)
      cnt_r <= cnt_r + 8'h01;

  // ==========================================================
  // Properties
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_sdf_take;
    take && sdf;
  endsequence

  sequence s_data_next;
    valid && !ctl;
  endsequence

  a_word_hold: assert property (valid && !ready |=> valid && $stable(word) && $stable(kflag))
    else $error("link word changed before taken");
  a_sdf_fields: assert property (valid && sdf |-> word[31:24] == dfp_pkg::D_RSVD && word[15:8] == dfp_pkg::D_SDF_ID)
    else $error("bad start word fields");
  a_ctrl_code: assert property (valid && ctl |-> sdf || edf)
    else $error("unknown control word");
  a_k_codes: assert property (valid && !ctl |-> (fl | en) == kflag)
    else $error("bad control symbol in data word");
  a_fill_pad: assert property (valid && !ctl |-> (fl & ~{fl[2:0] | en[2:0], 1'b0}) == 4'h0
                                && (en[2:0] & ~fl[3:1]) == 3'h0)
    else $error("fill placement wrong");
  a_sdf_data: assert property (s_sdf_take |=> s_data_next)
    else $error("start word not followed by data");
  a_edf_len: assert property (take && edf |-> cnt_r >= 1 && cnt_r <= MAX_WORDS)
    else $error("frame length out of range");
  a_frame_cap: assert property (take && !ctl |-> cnt_r < MAX_WORDS)
    else $error("too many data words");
  a_rx_unpack: assert property (take && !ctl |=> !ready ##[1:6] ready)
    else $error("receiver unpack timing wrong");
endmodule

// ===== test/data_frame_nchar_packer_tb_top.sv
// Purpose: Packer feeding receiver; checks wire words and received chars
// Assumes: MAX_WORDS shortened to 2 so frames split often
// Notes:   Expected words are built from the chars sent
module data_frame_nchar_packer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MAXW = 2;

  logic                   clock, nrst, nc_valid, nc_ready, frame_open;
  logic [7:0]             nc_data, vc_num, seq_num, rx_data, rx_vc, rx_seq, rnd;
  dfp_pkg::dfp_nchar_type nc_kind, rx_kind;
  logic                   rx_valid, rx_end, rx_crc_ok, rx_err;
  logic [35:0]            wq[$];
  logic [8:0]             cq[$];
  logic [35:0]            cur;
  logic [8:0]             s;
  logic [15:0]            crc;
  int                     pos, n, num_errors, checked;
  int                     edf_seen, end_seen;

  dfp_link_if lk ();
  dfp_tx #(.MAX_WORDS(MAXW)) i_dfp_tx (.clock(clock), .nrst(nrst), .nc_valid(nc_valid), .nc_data(nc_data),
    .nc_kind(nc_kind), .nc_ready(nc_ready), .vc_num(vc_num), .seq_num(seq_num), .frame_open(frame_open), .lk(lk));
  dfp_rx i_dfp_rx (.clock(clock), .nrst(nrst), .lk(lk), .nc_valid(rx_valid), .nc_data(rx_data), .nc_kind(rx_kind),
    .nc_vc(rx_vc), .frame_end(rx_end), .crc_ok(rx_crc_ok), .seq_num(rx_seq), .code_err(rx_err));
  dfp_link_monitor #(.MAX_WORDS(MAXW)) i_dfp_link_monitor (.clock(clock), .nrst(nrst), .word(lk.word),
    .kflag(lk.kflag), .valid(lk.valid), .ready(lk.ready));

  // ==========================================================
  // Helpers
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic [15:0] crc_word(logic [15:0] c, logic [31:0] w, int nb);
    for (int i = 0; i < nb; i++)
    begin
      c = c ^ {w[i*8 +: 8], 8'h00};
      for (int j = 0; j < 8; j++)
        c = c[15] ? ((c << 1) ^ dfp_pkg::CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [1:0] kind_of(logic [8:0] v);
    return !v[8] ? 2'h0 : v[7:0] == dfp_pkg::K_EOP ? 2'h1 : v[7:0] == dfp_pkg::K_EEP ? 2'h2 : 2'h3;
  endfunction

  task automatic check(logic [35:0] seen, logic [35:0] exp, string msg);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL at %0t: %s", $time, msg);
    end
  endtask

  task automatic put(logic [8:0] v);
    cur[pos*8 +: 8] = v[7:0];
    cur[32+pos] = v[8];
    pos++;
    if (pos == 4)
    begin
      wq.push_back(cur);
      pos = 0;
    end
  endtask

  // Held until taken; packet end pads the word with fills
  task automatic send(logic [1:0] k, logic [7:0] d);
    nc_valid <= 1'b1;
    nc_data <= d;
    nc_kind <= dfp_pkg::dfp_nchar_type'(k);
    do @(posedge clock); while (nc_ready !== 1'b1);
    if (k == 2'h0)
      put({1'b0, d});
    else
    begin
      put({1'b1, k == 2'h1 ? dfp_pkg::K_EOP : dfp_pkg::K_EEP});
      while (pos != 0)
        put({1'b1, dfp_pkg::K_FILL});
    end
  endtask

  task automatic report_and_stop();
    $display("checked %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Observers
  always @(posedge clock)
  begin
    if (nrst && lk.valid === 1'b1 && lk.ready === 1'b1)
    begin
      if (lk.kflag === 4'h1 && lk.word[7:0] === dfp_pkg::K_COMMA)
      begin
        check(lk.word, {dfp_pkg::D_RSVD, vc_num, dfp_pkg::D_SDF_ID, dfp_pkg::K_COMMA}, "start word");
        crc = crc_word(dfp_pkg::CRC_INIT, lk.word, 4);
      end
      else if (lk.kflag === 4'h1)
      begin
        edf_seen++;
        crc = crc_word(crc, lk.word, 2);
        check(lk.word, {crc, seq_num, dfp_pkg::K_EDF}, "end word");
      end
      else
      begin
        check({lk.kflag, lk.word}, wq.pop_front(), "data word");
        crc = crc_word(crc, lk.word, 4);
        for (int i = 0; i < 4; i++)
          cq.push_back({lk.kflag[i], lk.word[i*8 +: 8]});
      end
    end
  end

  always @(posedge clock)
  begin
    if (nrst)
      check(rx_err, 1'b0, "code error");
    if (nrst && rx_valid === 1'b1)
    begin
      s = cq.pop_front();
      check(rx_kind, kind_of(s), "received kind");
      if (!s[8])
        check(rx_data, s[7:0], "received data");
      check(rx_vc, vc_num, "received channel");
    end
    if (nrst && rx_end === 1'b1)
    begin
      end_seen++;
      check(rx_seq, seq_num, "received sequence");
      check(rx_crc_ok, 1'b1, "received crc");
    end
  end

  // ==========================================================
  // Stimulus
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial
  begin
    #100000;
    num_errors++;
    report_and_stop();
  end

  initial
  begin
    nrst = 1'b0;
    nc_valid = 1'b0;
    nc_data = 8'h00;
    nc_kind = dfp_pkg::NC_DATA;
    vc_num = 8'h00;
    seq_num = 8'h00;
    rnd = 8'h29;
    pos = 0;
    num_errors = 0;
    checked = 0;
    edf_seen = 0;
    end_seen = 0;
    repeat (16) @(posedge clock);
    nrst <= 1'b1;
    for (int t = 0; t < 3; t++)
    begin
      @(posedge clock);
      rnd = lfsr(rnd);
      vc_num <= rnd;
      rnd = lfsr(rnd);
      seq_num <= rnd;
      for (int p = 0; p < 10; p++)
      begin
        rnd = lfsr(rnd);
        // First test walks the packet end through every lane
        n = (t == 0) ? p % 5 + 1 : rnd % 9 + 1;
        for (int i = 0; i < n; i++)
        begin
          rnd = lfsr(rnd);
          send(2'h0, (t == 0 && i == 0) ? (p[0] ? 8'hff : 8'h00) : rnd);
        end
        send(rnd[0] ? 2'h2 : 2'h1, 8'h00);
      end
      nc_valid <= 1'b0;
      repeat (200) @(posedge clock);
      check(wq.size(), 0, "words left unsent");
      check(cq.size(), 0, "chars left unreceived");
      check(frame_open, 1'b0, "frame left open");
      // Every end word on the link must show up as one frame end pulse
      check(end_seen, edf_seen, "frame ends received");
      $display("test %0d done, errors %0d", t, num_errors);
    end
    report_and_stop();
  end
endmodule
